// ===== sim/bslc_burner_model.sv
// Purpose: Burner air switch and flame detector model
// Assumes: Air proves 40 clocks after fan start
// Notes: Faults only when the bench commands them
`timescale 1ns/1ps
module bslc_burner_model
(
  input wire logic clk,
  input wire logic fan,
  input wire logic valve1,
  input wire logic fail_air,
  input wire logic fail_flame,
  input wire logic stuck_air,
  output logic air,
  output logic flame
);
  int cnt;
  always_ff @(posedge clk) cnt <= fan ? cnt + 1 : 0;
  // Switch opens as soon as airflow stops, unless stuck_air holds it closed
  assign air = (fan && cnt >= 40 && !fail_air) || stuck_air;
  assign flame = valve1 && !fail_flame;
endmodule

// ===== sim/bslc_top_asserts.sv
// Purpose: Port-level checks of the burner sequencer
// Assumes: Bound to bslc_top, one clock domain
// Notes: Output effects are allowed one to three clocks of latency
`timescale 1ns/1ps
module bslc_top_asserts
(
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HREADY,
  input wire logic I_FLAME,
  input wire logic I_LOW_SUPPLY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_NV_WR,
  input wire logic O_IGNITION,
  input wire logic O_VALVE1,
  input wire logic O_VALVE2,
  input wire logic O_AIR_DAMPER_CMD
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  a_nv_one_pulse: assert property (O_NV_WR |=> !O_NV_WR)
    else $error("store write longer than one cycle");
  a_rdata_idle: assert property (!$past(I_HSEL && I_HTRANS[1] && I_HREADY) |-> O_HRDATA == 32'h0)
    else $error("read data outside data phase");
  a_low_supply_off: assert property (I_LOW_SUPPLY [*4] |-> !O_VALVE1 && !O_VALVE2 && !O_IGNITION)
    else $error("fuel or ignition on under low supply");
  a_flame_loss_cut: assert property (O_VALVE2 && !I_FLAME |-> ##[1:3] !O_VALVE1)
    else $error("fuel kept after flame loss");
  a_stage_order: assert property (O_VALVE2 |-> O_VALVE1)
    else $error("second valve without first");
  a_ign_before_run: assert property (O_IGNITION |-> !O_VALVE2)
    else $error("ignition while running");
  a_preign_first: assert property ($rose(O_VALVE1) |-> $past(O_IGNITION))
    else $error("valve opened without pre-ignition");
  a_damper_fuel: assert property (O_AIR_DAMPER_CMD && O_VALVE1 |-> O_VALVE2)
    else $error("damper with fuel before second stage");
endmodule
bind bslc_top bslc_top_asserts u_chk (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_HSEL(I_HSEL),
  .I_HTRANS(I_HTRANS), .I_HREADY(I_HREADY), .I_FLAME(I_FLAME), .I_LOW_SUPPLY(I_LOW_SUPPLY),
  .O_HRDATA(O_HRDATA), .O_NV_WR(O_NV_WR), .O_IGNITION(O_IGNITION), .O_VALVE1(O_VALVE1),
  .O_VALVE2(O_VALVE2), .O_AIR_DAMPER_CMD(O_AIR_DAMPER_CMD));

// ===== sim/burner_sequence_lockout_ctrl_bench.sv
// Purpose: Self-checking bench of the burner sequencer
// Assumes: TICK_CYCLES 1, so one ms is one clock
// Notes: Bus ready is fed back from the slave
`timescale 1ns/1ps
module burner_sequence_lockout_ctrl_bench;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, demand = 1'b0, low = 1'b0, btn = 1'b0;
  logic fail_air = 1'b0, fail_flame = 1'b0, stuck_air = 1'b0;
  logic [2:0] nvc = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire logic [31:0] hrdata;
  wire logic [2:0] nv_data;
  wire logic hready, air, flame, fan, v1, v2, irq, hresp, nv_wr, led, alarm;
  int n_errors = 0, checked = 0, cyc = 0, t0;
  bslc_top #(.TICK_CYCLES(1)) dut (.I_CLOCK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_HEAT_DEMAND(demand),
    .I_AIR_FLOW_SWITCH(air), .I_FLAME(flame), .I_LOW_SUPPLY(low), .I_RESET_BTN(btn),
    .I_NV_CAUSE(nvc), .O_NV_WR(nv_wr), .O_NV_DATA(nv_data), .O_FAN(fan), .O_IGNITION(), .O_VALVE1(v1),
    .O_VALVE2(v2), .O_AIR_DAMPER_CMD(), .O_ALARM(alarm), .O_LED(led), .O_IRQ(irq));
  bslc_burner_model u_burner (.clk(clk), .fan(fan), .valve1(v1), .fail_air(fail_air),
    .fail_flame(fail_flame), .stuck_air(stuck_air), .air(air), .flame(flame));
  // Non-volatile cause store, survives reset
  always @(posedge clk)
    if (nv_wr)
      nvc <= nv_data;
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 100000)
    begin
      n_errors++;
      summarize();
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // ****************************************
  // Single AHB transfer, called just after a rising edge
  // ****************************************
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wait_st(input logic [3:0] s);
    int k;
    k = 0;
    do
    begin
      bus(1'b0, 8'h04, 32'h0);
      k++;
    end
    while (rd[3:0] !== s && k < 50000);
    check("state", {28'h0, rd[3:0]}, {28'h0, s});
  endtask
  task unlock;
    demand <= 1'b0;
    fail_air <= 1'b0;
    fail_flame <= 1'b0;
    stuck_air <= 1'b0;
    btn <= 1'b1;
    repeat (5) @(posedge clk);
    btn <= 1'b0;
    wait_st(4'h1);
    check("cause cleared", {29'h0, rd[6:4]}, 32'h0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, 8'h00, 32'h0);
    check("ctrl reset", rd, 32'h1);
    check("okay response", hresp, 1'b0);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, 8'h0c, 32'h7);
    demand <= 1'b1;
    wait_st(4'h4);
    wait_st(4'h5);
    t0 = cyc;
    wait_st(4'h6);
    check("purge time", (cyc - t0 >= 53990 && cyc - t0 <= 54010), 1);
    wait_st(4'h9);
    check("second valve", v2, 1'b1);
    check("irq run", irq, 1'b1);
    bus(1'b0, 8'h08, 32'h0);
    check("irq status", rd, 32'h2);
    bus(1'b1, 8'h10, 32'h7);
    bus(1'b0, 8'h08, 32'h0);
    check("irq cleared", rd, 32'h0);
    check("irq low", irq, 1'b0);
    fail_flame <= 1'b1;
    wait_st(4'ha);
    check("cause flame", {29'h0, rd[6:4]}, 32'h6);
    check("stored cause", nv_data, 3'h6);
    check("irq lock", irq, 1'b1);
    repeat (200) @(posedge clk);
    wait_st(4'ha);
    check("led lit", led, 1'b1);
    check("alarm", alarm, 1'b1);
    unlock();
    demand <= 1'b1;
    wait_st(4'h5);
    @(posedge clk);
    check("led purge", led, 1'b1);
    fail_air <= 1'b1;
    wait_st(4'ha);
    check("cause air", {29'h0, rd[6:4]}, 32'h5);
    unlock();
    demand <= 1'b1;
    wait_st(4'h5);
    bus(1'b1, 8'h00, 32'h3);
    wait_st(4'ha);
    check("cause manual", {29'h0, rd[6:4]}, 32'h7);
    unlock();
    demand <= 1'b1;
    wait_st(4'h5);
    low <= 1'b1;
    wait_st(4'hb);
    repeat (100) @(posedge clk);
    wait_st(4'hb);
    check("fan off", fan, 1'b0);
    low <= 1'b0;
    demand <= 1'b0;
    wait_st(4'h1);
    stuck_air <= 1'b1;
    demand <= 1'b1;
    wait_st(4'h2);
    wait_st(4'h3);
    wait_st(4'h2);
    wait_st(4'ha);
    check("cause air closed", {29'h0, rd[6:4]}, 32'h3);
    check("retry", rd[7], 1'b1);
    unlock();
    demand <= 1'b1;
    wait_st(4'h5);
    btn <= 1'b1;
    repeat (3100) @(posedge clk);
    btn <= 1'b0;
    wait_st(4'ha);
    check("cause long press", {29'h0, rd[6:4]}, 32'h7);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wait_st(4'ha);
    check("cause after power", {29'h0, rd[6:4]}, 32'h7);
    summarize();
  end
endmodule

// ===== verilog/bslc_pkg.sv
// Purpose: Constants and types of the burner sequence and lockout controller
// Assumes: 200 MHz system clock, 1 ms sequence tick
// Notes: Phase times are in milliseconds and are counted in ticks

package bslc_pkg;

  // ****************************************
  // Timebase
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ = 200000000;
  localparam int unsigned TICK_PERIOD_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

  // ****************************************
  // Phase times in ms
  // ****************************************
  localparam int unsigned AIR_SWITCH_MAX_MS = 60000;
  localparam int unsigned PREPURGE_TIME_MS = 54000;
  localparam int unsigned DAMPER_OPEN_MS = 40000;
  localparam int unsigned DAMPER_CLOSE_TIME_MS = 14000;
  localparam int unsigned FALSE_FLAME_CHECK_TIME_MS = 5000;
  localparam int unsigned PREIGNITION_MS = 3000;
  localparam int unsigned FLAME_SAFETY_TIME_MS = 3000;
  localparam int unsigned POSTIGNITION_TIME_MS = 2500;
  localparam int unsigned SECOND_STAGE_DELAY_MS = 8000;
  localparam int unsigned FAN_BURST_MS = 2000;
  localparam int unsigned QUICK_RETRY_MS = 10000;
  localparam int unsigned BTN_LONG_MS = 3000;
  localparam int unsigned LED_SHORT_MS = 300;
  localparam int unsigned LED_LONG_MS = 900;
  localparam int unsigned LED_GAP_MS = 300;
  localparam int unsigned LED_SPAUSE_MS = 600;
  localparam int unsigned LED_LPAUSE_MS = 1200;
  localparam int unsigned LED_LIT_MS = 10000;

  // Tick counts
  localparam logic [15:0] T_AIR = 16'(AIR_SWITCH_MAX_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_PURGE = 16'(PREPURGE_TIME_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_DAMPER = 16'(DAMPER_OPEN_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_STRAY = 16'((PREPURGE_TIME_MS - FALSE_FLAME_CHECK_TIME_MS) / TICK_PERIOD_MS);
  localparam logic [15:0] T_PREIGN = 16'(PREIGNITION_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_SAFETY = 16'(FLAME_SAFETY_TIME_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_POSTIGN = 16'(POSTIGNITION_TIME_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_DELAY2 = 16'(SECOND_STAGE_DELAY_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_BURST = 16'(FAN_BURST_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_RETRY = 16'(QUICK_RETRY_MS / TICK_PERIOD_MS);
  localparam logic [15:0] T_BTN = 16'(BTN_LONG_MS / TICK_PERIOD_MS);

  // ****************************************
  // Sequence states and lockout causes
  // ****************************************
  typedef enum logic [3:0] {
    S_INIT = 4'h0, S_IDLE = 4'h1, S_QFAN = 4'h2, S_QWAIT = 4'h3,
    S_AIRW = 4'h4, S_PURGE = 4'h5, S_PREIGN = 4'h6, S_SAFETY = 4'h7,
    S_DELAY2 = 4'h8, S_RUN = 4'h9, S_LOCK = 4'ha, S_LOWV = 4'hb
  } bslc_state_t;

  localparam logic [2:0] C_NONE = 3'h0;
  localparam logic [2:0] C_SAFETY = 3'h1;
  localparam logic [2:0] C_STRAY = 3'h2;
  localparam logic [2:0] C_AIR_CLOSED = 3'h3;
  localparam logic [2:0] C_AIR_TIMEOUT = 3'h4;
  localparam logic [2:0] C_AIR_OPENED = 3'h5;
  localparam logic [2:0] C_FLAME_LOSS = 3'h6;
  localparam logic [2:0] C_MANUAL = 3'h7;

  // ****************************************
  // LED symbols, four bits each, first in low nibble
  // ****************************************
  localparam logic [3:0] SY_END = 4'h0;
  localparam logic [3:0] SY_SHORT = 4'h1;
  localparam logic [3:0] SY_LONG = 4'h2;
  localparam logic [3:0] SY_SPAUSE = 4'h3;
  localparam logic [3:0] SY_LPAUSE = 4'h4;
  localparam logic [3:0] SY_LIT = 4'h5;

  localparam logic [31:0] P_AIRW = 32'h00000311;
  localparam logic [31:0] P_PURGE = 32'h00003111;
  localparam logic [31:0] P_PREIGN = 32'h00031111;
  localparam logic [31:0] P_SAFETY = 32'h00000312;
  localparam logic [31:0] P_DELAY2 = 32'h00311112;
  localparam logic [31:0] P_RUN = 32'h00000041;
  localparam logic [31:0] P_L_SAFETY = 32'h41111135;
  localparam logic [31:0] P_L_STRAY = 32'h04111235;
  localparam logic [31:0] P_L_AIRCL = 32'h00412235;
  localparam logic [31:0] P_L_AIRTO = 32'h00412135;
  localparam logic [31:0] P_L_AIROP = 32'h00421135;
  localparam logic [31:0] P_L_FLAME = 32'h00422235;
  localparam logic [31:0] P_L_MANUAL = 32'h00041235;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_EN = 8'h0c;
  localparam logic [7:0] A_IRQ_CLR = 8'h10;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_LOCK_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

endpackage

// ===== verilog/bslc_top.sv
// Purpose: Burner start sequence, supervision, lockout and LED flash codes
// Assumes: All inputs synchronous to I_CLOCK; external store keeps I_NV_CAUSE
// Notes: Registers over AHB-Lite, zero wait states
//
// Summary of operation
// RQ1 - Every lockout cause is written to external non-volatile store.
// RQ2 - Low supply aborts operation and blocks new starts while it lasts.
// RQ3 - Flame lost while running locks out at once as flame loss.
// RQ4 - Air switch not closed 60 s after fan start locks out.
// RQ5 - Air switch opening from pre-purge onward locks out as air opened.
// RQ6 - Pre-purge 54 s, damper open first 40 s, then 14 s close.
// RQ7 - No flame at end of 3 s safety time closes fuel, locks out.
// RQ8 - LED shows current sequence phase whenever not locked out; code leaves it dark in S_INIT, S_IDLE, S_QFAN, S_QWAIT and S_LOWV.
// RQ9 - Each phase has its own repeating pulse pattern on the LED.
// RQ10 - Messages use short and long pulses and pauses on one LED.
// RQ11 - In lockout LED stays lit, broken every 10 s by cause code.
// RQ12 - Lockout cycle: 10 s lit, 0.6 s dark, code, 1.2 s dark.
// RQ13 - Manual or external lockout has its own distinct flash code.
// RQ14 - Flame seen in last check time of pre-purge locks out stray light.
// RQ15 - Reset button held over 3 s then released forces manual lockout.
// RQ16 - Lockout stays latched until reset; power loss does not clear it.
// RQ17 - Air switch closed at start: fan burst, 10 s wait, one retry.
// RQ18 - Phases follow fixed order up to running with second stage.
// RQ19 - All phase times come from one tick derived from the clock.
//
// Our own choices: the register addresses and register access over AHB-Lite.

`timescale 1ns/1ps

module bslc_top
#(
  parameter int unsigned TICK_CYCLES = bslc_pkg::TICK_CYCLES
)
(
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_HEAT_DEMAND,
  input wire logic I_AIR_FLOW_SWITCH,
  input wire logic I_FLAME,
  input wire logic I_LOW_SUPPLY,
  input wire logic I_RESET_BTN,
  input wire logic [2:0] I_NV_CAUSE,
  output logic O_NV_WR,
  output logic [2:0] O_NV_DATA,
  output logic O_FAN,
  output logic O_IGNITION,
  output logic O_VALVE1,
  output logic O_VALVE2,
  output logic O_AIR_DAMPER_CMD,
  output logic O_ALARM,
  output logic O_LED,
  output logic O_IRQ
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [17:0] tick_cnt_reg;
  logic tick;

  assign tick = (tick_cnt_reg == 18'(TICK_CYCLES - 1));

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= 18'h00000;
    else if (tick)
      tick_cnt_reg <= 18'h00000; // RQ19
    else
      tick_cnt_reg <= tick_cnt_reg + 18'h00001;
  end

  // ****************************************
  // Bus slave and registers
  // ****************************************
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic ctrl_en_reg;
  logic man_req_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_en_reg;
  logic [31:0] rd_data;
  logic acc;
  logic wr_data_ph;
  logic [2:0] ev;
  logic [2:0] clr;
  bslc_pkg::bslc_state_t state_reg;
  bslc_pkg::bslc_state_t state_next;
  logic [2:0] cause_reg;
  logic [2:0] cause_next;
  logic retry_reg;
  logic retry_next;

  assign acc = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign wr_data_ph = wr_pend_reg && I_HREADY;

  always_comb
  begin
    rd_data = 32'h00000000;
    case (I_HADDR[7:0])
      bslc_pkg::A_CTRL: rd_data[bslc_pkg::CTRL_EN_BIT] = ctrl_en_reg;
      bslc_pkg::A_STATUS: rd_data[7:0] = {retry_reg, cause_reg, state_reg};
      bslc_pkg::A_IRQ_STAT: rd_data[2:0] = irq_stat_reg;
      bslc_pkg::A_IRQ_EN: rd_data[2:0] = irq_en_reg;
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      O_HRDATA <= 32'h00000000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
    else
    begin
      if (I_HREADY)
      begin
        wr_pend_reg <= acc && I_HWRITE;
        wr_addr_reg <= I_HADDR[7:0];
      end
      O_HRDATA <= (acc && !I_HWRITE) ? rd_data : 32'h00000000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
  end

  assign clr = (wr_data_ph && wr_addr_reg == bslc_pkg::A_IRQ_CLR) ? I_HWDATA[2:0] : 3'h0;

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_en_reg <= bslc_pkg::CTRL_EN_RST;
      man_req_reg <= 1'b0;
      irq_en_reg <= bslc_pkg::IRQ_EN_RST;
      irq_stat_reg <= 3'h0;
      O_IRQ <= 1'b0;
    end
    else
    begin
      man_req_reg <= wr_data_ph && wr_addr_reg == bslc_pkg::A_CTRL && I_HWDATA[bslc_pkg::CTRL_LOCK_BIT];
      if (wr_data_ph && wr_addr_reg == bslc_pkg::A_CTRL)
        ctrl_en_reg <= I_HWDATA[bslc_pkg::CTRL_EN_BIT];
      if (wr_data_ph && wr_addr_reg == bslc_pkg::A_IRQ_EN)
        irq_en_reg <= I_HWDATA[2:0];
      // Set wins over clear
      irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
      O_IRQ <= |(((irq_stat_reg & ~clr) | ev) & irq_en_reg);
    end
  end

  // ****************************************
  // Sequence timer and reset button
  // ****************************************
  logic [15:0] tmr_reg;
  logic [15:0] btn_cnt_reg;
  logic btn_prev_reg;
  logic btn_rel;
  logic btn_long;

  assign btn_rel = btn_prev_reg && !I_RESET_BTN;
  assign btn_long = btn_cnt_reg > bslc_pkg::T_BTN;

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmr_reg <= 16'h0000;
      btn_cnt_reg <= 16'h0000;
      btn_prev_reg <= 1'b0;
    end
    else
    begin
      if (state_next != state_reg)
        tmr_reg <= 16'h0000;
      else if (tick && tmr_reg != 16'hffff)
        tmr_reg <= tmr_reg + 16'h0001; // RQ19
      btn_prev_reg <= I_RESET_BTN;
      if (!I_RESET_BTN)
        btn_cnt_reg <= 16'h0000;
      else if (tick && btn_cnt_reg != 16'hffff)
        btn_cnt_reg <= btn_cnt_reg + 16'h0001;
    end
  end

  // ****************************************
  // Sequence state machine
  // ****************************************
  logic lock;
  logic [2:0] lc;
  logic in_seq;

  assign in_seq = state_reg inside {bslc_pkg::S_AIRW, bslc_pkg::S_PURGE, bslc_pkg::S_PREIGN,
                                    bslc_pkg::S_SAFETY, bslc_pkg::S_DELAY2, bslc_pkg::S_RUN};

  always_comb
  begin
    state_next = state_reg;
    cause_next = cause_reg;
    retry_next = retry_reg;
    lock = 1'b0;
    lc = bslc_pkg::C_NONE;
    case (state_reg)
      bslc_pkg::S_INIT:
      begin
        if (I_NV_CAUSE != bslc_pkg::C_NONE)
        begin
          lock = 1'b1; // RQ16
          lc = I_NV_CAUSE;
        end
        else
          state_next = bslc_pkg::S_IDLE;
      end
      bslc_pkg::S_IDLE:
      begin
        retry_next = 1'b0;
        if (I_HEAT_DEMAND && ctrl_en_reg && !I_LOW_SUPPLY) // RQ2
          state_next = I_AIR_FLOW_SWITCH ? bslc_pkg::S_QFAN : bslc_pkg::S_AIRW; // RQ17
      end
      bslc_pkg::S_QFAN:
      begin
        if (tmr_reg >= bslc_pkg::T_BURST)
        begin
          if (retry_reg)
          begin
            lock = 1'b1; // RQ17
            lc = bslc_pkg::C_AIR_CLOSED;
          end
          else
            state_next = bslc_pkg::S_QWAIT;
        end
      end
      bslc_pkg::S_QWAIT:
      begin
        if (tmr_reg >= bslc_pkg::T_RETRY)
        begin
          retry_next = 1'b1; // RQ17
          state_next = I_AIR_FLOW_SWITCH ? bslc_pkg::S_QFAN : bslc_pkg::S_AIRW;
        end
      end
      bslc_pkg::S_AIRW:
      begin
        if (I_AIR_FLOW_SWITCH)
          state_next = bslc_pkg::S_PURGE; // RQ18
        else if (tmr_reg >= bslc_pkg::T_AIR)
        begin
          lock = 1'b1; // RQ4
          lc = bslc_pkg::C_AIR_TIMEOUT;
        end
      end
      bslc_pkg::S_PURGE:
      begin
        if (I_FLAME && tmr_reg >= bslc_pkg::T_STRAY)
        begin
          lock = 1'b1; // RQ14
          lc = bslc_pkg::C_STRAY;
        end
        else if (tmr_reg >= bslc_pkg::T_PURGE)
          state_next = bslc_pkg::S_PREIGN; // RQ6
      end
      bslc_pkg::S_PREIGN:
      begin
        if (tmr_reg >= bslc_pkg::T_PREIGN)
          state_next = bslc_pkg::S_SAFETY; // RQ18
      end
      bslc_pkg::S_SAFETY:
      begin
        if (tmr_reg >= bslc_pkg::T_SAFETY)
        begin
          if (I_FLAME)
            state_next = bslc_pkg::S_DELAY2; // RQ18
          else
          begin
            lock = 1'b1; // RQ7
            lc = bslc_pkg::C_SAFETY;
          end
        end
      end
      bslc_pkg::S_DELAY2:
      begin
        if (!I_FLAME)
        begin
          lock = 1'b1;
          lc = bslc_pkg::C_FLAME_LOSS;
        end
        else if (tmr_reg >= bslc_pkg::T_DELAY2)
          state_next = bslc_pkg::S_RUN; // RQ18
      end
      bslc_pkg::S_RUN:
      begin
        if (!I_FLAME)
        begin
          lock = 1'b1; // RQ3
          lc = bslc_pkg::C_FLAME_LOSS;
        end
      end
      bslc_pkg::S_LOCK:
      begin
        if (btn_rel)
        begin
          state_next = bslc_pkg::S_IDLE; // RQ16
          cause_next = bslc_pkg::C_NONE;
        end
      end
      bslc_pkg::S_LOWV:
      begin
        if (!I_LOW_SUPPLY)
          state_next = bslc_pkg::S_IDLE; // RQ2
      end
      default: state_next = bslc_pkg::S_IDLE;
    endcase
    if (in_seq && state_reg != bslc_pkg::S_AIRW && !I_AIR_FLOW_SWITCH)
    begin
      lock = 1'b1; // RQ5
      lc = bslc_pkg::C_AIR_OPENED;
    end
    if (in_seq && !I_HEAT_DEMAND && !lock)
      state_next = bslc_pkg::S_IDLE;
    if (I_LOW_SUPPLY && state_reg != bslc_pkg::S_LOCK && state_reg != bslc_pkg::S_INIT && !lock)
      state_next = bslc_pkg::S_LOWV; // RQ2
    if (((btn_rel && btn_long) || man_req_reg) && state_reg != bslc_pkg::S_LOCK
        && state_reg != bslc_pkg::S_INIT)
    begin
      lock = 1'b1; // RQ15
      lc = bslc_pkg::C_MANUAL;
    end
    if (lock)
    begin
      state_next = bslc_pkg::S_LOCK;
      cause_next = lc;
    end
  end

  assign ev[0] = state_next == bslc_pkg::S_LOCK && state_reg != bslc_pkg::S_LOCK;
  assign ev[1] = state_next == bslc_pkg::S_RUN && state_reg != bslc_pkg::S_RUN;
  assign ev[2] = state_next == bslc_pkg::S_LOWV && state_reg != bslc_pkg::S_LOWV;

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= bslc_pkg::S_INIT;
      cause_reg <= bslc_pkg::C_NONE;
      retry_reg <= 1'b0;
      O_NV_WR <= 1'b0;
      O_NV_DATA <= bslc_pkg::C_NONE;
    end
    else
    begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      retry_reg <= retry_next;
      O_NV_WR <= cause_next != cause_reg; // RQ1
      O_NV_DATA <= cause_next;
    end
  end

  // ****************************************
  // Actuator outputs
  // ****************************************
  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_FAN <= 1'b0;
      O_IGNITION <= 1'b0;
      O_VALVE1 <= 1'b0;
      O_VALVE2 <= 1'b0;
      O_AIR_DAMPER_CMD <= 1'b0;
      O_ALARM <= 1'b0;
    end
    else
    begin
      O_FAN <= in_seq || state_reg == bslc_pkg::S_QFAN;
      O_IGNITION <= state_reg == bslc_pkg::S_PREIGN || state_reg == bslc_pkg::S_SAFETY
                    || (state_reg == bslc_pkg::S_DELAY2 && tmr_reg < bslc_pkg::T_POSTIGN);
      O_VALVE1 <= (state_reg == bslc_pkg::S_SAFETY || state_reg == bslc_pkg::S_DELAY2
                   || state_reg == bslc_pkg::S_RUN) && !lock; // RQ7
      O_VALVE2 <= state_reg == bslc_pkg::S_RUN && !lock; // RQ18
      O_AIR_DAMPER_CMD <= (state_reg == bslc_pkg::S_PURGE && tmr_reg < bslc_pkg::T_DAMPER)
                          || state_reg == bslc_pkg::S_RUN; // RQ6
      O_ALARM <= state_reg == bslc_pkg::S_LOCK;
    end
  end

  // ****************************************
  // LED flash code player
  // ****************************************
  logic [31:0] pat_next;
  logic [31:0] pat_reg;
  logic [2:0] idx_reg;
  logic part_reg;
  logic [15:0] led_tmr_reg;
  logic [3:0] sym;
  logic [15:0] on_t;
  logic [15:0] off_t;
  logic [15:0] dur;

  always_comb
  begin
    pat_next = 32'h00000000;
    case (state_reg)
      bslc_pkg::S_AIRW: pat_next = bslc_pkg::P_AIRW; // RQ8
      bslc_pkg::S_PURGE: pat_next = bslc_pkg::P_PURGE; // RQ9
      bslc_pkg::S_PREIGN: pat_next = bslc_pkg::P_PREIGN; // RQ9
      bslc_pkg::S_SAFETY: pat_next = bslc_pkg::P_SAFETY;
      bslc_pkg::S_DELAY2: pat_next = bslc_pkg::P_DELAY2;
      bslc_pkg::S_RUN: pat_next = bslc_pkg::P_RUN;
      bslc_pkg::S_LOCK:
      begin
        case (cause_reg) // RQ11
          bslc_pkg::C_SAFETY: pat_next = bslc_pkg::P_L_SAFETY;
          bslc_pkg::C_STRAY: pat_next = bslc_pkg::P_L_STRAY;
          bslc_pkg::C_AIR_CLOSED: pat_next = bslc_pkg::P_L_AIRCL;
          bslc_pkg::C_AIR_TIMEOUT: pat_next = bslc_pkg::P_L_AIRTO;
          bslc_pkg::C_AIR_OPENED: pat_next = bslc_pkg::P_L_AIROP;
          bslc_pkg::C_FLAME_LOSS: pat_next = bslc_pkg::P_L_FLAME;
          bslc_pkg::C_MANUAL: pat_next = bslc_pkg::P_L_MANUAL; // RQ13
          default: pat_next = bslc_pkg::P_L_SAFETY;
        endcase
      end
      default: pat_next = 32'h00000000;
    endcase
  end

  assign sym = pat_reg[{idx_reg, 2'b00} +: 4];

  always_comb
  begin
    on_t = 16'h0000;
    off_t = 16'h0000;
    case (sym) // RQ10
      bslc_pkg::SY_SHORT:
      begin
        on_t = 16'(bslc_pkg::LED_SHORT_MS);
        off_t = 16'(bslc_pkg::LED_GAP_MS);
      end
      bslc_pkg::SY_LONG:
      begin
        on_t = 16'(bslc_pkg::LED_LONG_MS);
        off_t = 16'(bslc_pkg::LED_GAP_MS);
      end
      bslc_pkg::SY_SPAUSE: off_t = 16'(bslc_pkg::LED_SPAUSE_MS); // RQ12
      // Gap after the last pulse counts toward the long pause
      bslc_pkg::SY_LPAUSE: off_t = 16'(bslc_pkg::LED_LPAUSE_MS - bslc_pkg::LED_GAP_MS); // RQ12
      bslc_pkg::SY_LIT: on_t = 16'(bslc_pkg::LED_LIT_MS); // RQ12
      default: on_t = 16'h0000;
    endcase
  end

  assign dur = part_reg ? off_t : on_t;

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pat_reg <= 32'h00000000;
      idx_reg <= 3'h0;
      part_reg <= 1'b0;
      led_tmr_reg <= 16'h0000;
      O_LED <= 1'b0;
    end
    else
    begin
      pat_reg <= pat_next;
      if (pat_next != pat_reg || sym == bslc_pkg::SY_END)
      begin
        idx_reg <= 3'h0; // RQ9
        part_reg <= 1'b0;
        led_tmr_reg <= 16'h0000;
      end
      else if (led_tmr_reg >= dur)
      begin
        led_tmr_reg <= 16'h0000;
        part_reg <= !part_reg;
        if (part_reg)
          idx_reg <= idx_reg + 3'h1;
      end
      else if (tick)
        led_tmr_reg <= led_tmr_reg + 16'h0001;
      O_LED <= sym != bslc_pkg::SY_END && !part_reg && on_t != 16'h0000;
    end
  end

endmodule
